// ### speed_monitor_pkg.sv
// Package with register map, field positions, reset values and timing counts
package speed_monitor_pkg;

  // Timing: parameters in milliseconds, clock period in nanoseconds
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIME_UNIT_NS = 1000000;
  localparam int CYCLES_PER_UNIT = TIME_UNIT_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h0C;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h10;
  localparam logic [7:0] PARAM_BASE_OFS = 8'h40;

  // Parameter table: word index from the base
  localparam int NUM_PARAMS = 14;
  localparam int P_STOP_SPEED = 0;
  localparam int P_DETECT_DELAY = 1;
  localparam int P_LOW_THR = 2;
  localparam int P_LOW_HYST = 3;
  localparam int P_POS_DELAY = 4;
  localparam int P_NEG_DELAY = 5;
  localparam int P_LIMIT_SPEED0 = 6;
  localparam int P_DECEL_TIME0 = 10;
  localparam logic [15:0] PARAM_RST = 16'h0000;

  // Control register fields
  localparam int CTRL_BRAKE_EN = 0;
  localparam int CTRL_TRIP_CLR = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status register fields
  localparam int ST_TRIP = 0;
  localparam int ST_BELOW = 1;
  localparam int ST_LIMIT_MON = 2;
  localparam int ST_POS_MON = 3;
  localparam int ST_NEG_MON = 4;
  localparam int ST_BRAKE = 5;
  localparam int ST_SET_MON = 8;

  // Interrupt bits
  localparam int NUM_IRQ = 5;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_BELOW_FALL = 1;
  localparam int IRQ_BELOW_RISE = 2;
  localparam int IRQ_LIMIT_START = 3;
  localparam int IRQ_DIR_START = 4;
  localparam logic [4:0] IRQ_RST = 5'h00;

  // Number of limit sets
  localparam int NUM_SETS = 4;

  // Timer slots
  localparam int NUM_TIMERS = 10;
  localparam int T_DECEL0 = 0;
  localparam int T_POS = 4;
  localparam int T_NEG = 5;
  localparam int T_LIM_CMD = 6;
  localparam int T_LIM_FB = 7;
  localparam int T_DIR_CMD = 8;
  localparam int T_DIR_FB = 9;

endpackage

// ### monitor_delay_timer.sv
// Delay timer that reports when its run level has lasted a given cycle count
`timescale 1ns/1ns
module monitor_delay_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [31:0] limit,
  output logic done
);

  logic [31:0] cnt_q; // Cycles since run rose, saturating at limit

  // Count while running, restart whenever run drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h00000000;
    end else if (!run) begin
      cnt_q <= 32'h00000000;
    end else if (cnt_q < limit) begin
      cnt_q <= cnt_q + 32'h00000001;
    end
  end

  // Done once limit cycles of run have passed
  assign done = run && (cnt_q >= limit);

endmodule // monitor_delay_timer

// ### safe_speed_direction_monitor.sv
// Speed and direction safety monitor with APB registers and trip latch
// Notes on behaviour
// - Limit request low starts, high ends monitoring
// - Wait set deceleration time before comparing
// - Four sets of threshold and deceleration time
// - Several sets active: smallest threshold wins
// - Command over threshold trips after detect delay
// - Feedback over threshold continuously trips
// - Below output on when both speeds low
// - Below output off when either exceeds
// - Turn on again below threshold minus hysteresis
// - Brake released only while brake output on
// - Direction request low starts, high ends it
// - Positive request supervises increasing direction
// - Negative request supervises decreasing direction
// - Separate start delays per direction
// - Speed in supervised direction within stop speed
// - Command over stop speed trips after delay
// - Feedback over stop speed continuously trips
// - Request back high ends direction supervision
`timescale 1ns/1ns
module safe_speed_direction_monitor #(
  parameter int CYCLES_PER_UNIT = speed_monitor_pkg::CYCLES_PER_UNIT
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LIMITED_SPEED_REQUEST_N,
  input wire logic LIMIT_SET1_REQUEST_N,
  input wire logic LIMIT_SET2_REQUEST_N,
  input wire logic LIMIT_SET3_REQUEST_N,
  input wire logic LIMIT_SET4_REQUEST_N,
  input wire logic POSITIVE_DIR_REQUEST_N,
  input wire logic NEGATIVE_DIR_REQUEST_N,
  input wire logic signed [15:0] SPEED_CMD,
  input wire logic signed [15:0] SPEED_FB,
  output logic TORQUE_OFF_TRIP,
  output logic BELOW_SPEED_OUT,
  output logic BRAKE_RELEASE_OUT,
  output logic IRQ
);

  // Register state
  logic [15:0] param_q [speed_monitor_pkg::NUM_PARAMS]; // Speed and time settings
  logic brake_en_q; // Software brake release request
  logic trip_q; // Latched torque-off trip
  logic below_q; // Below-speed output state
  logic rearm_q; // Below output has gone off at least once
  logic [4:0] irq_status_q; // Sticky event bits
  logic [4:0] irq_enable_q; // Event enables
  logic [31:0] prdata_q; // Read data captured in setup
  logic lim_cmd_pend_q; // Limit command overspeed seen
  logic dir_cmd_pend_q; // Direction command overspeed seen
  logic lim_mon_q; // Previous limit monitoring level
  logic dir_mon_q; // Previous direction monitoring level

  // Decoded bus strobes
  logic setup_phase; // APB setup cycle
  logic wr_access; // Write takes effect at this edge
  logic addr_ok; // Address is mapped
  logic is_param; // Address hits the parameter table
  logic [3:0] param_idx; // Parameter word index
  logic trip_clr; // Write of the trip clear bit
  logic [4:0] irq_clr; // Write to the clear register

  // Monitor signals
  logic [3:0] set_act; // Limit sets requested
  logic [3:0] set_mon; // Limit sets past their deceleration time
  logic lim_mon; // Limit monitoring running
  logic [15:0] lim_thr; // Selected limit threshold
  logic [15:0] cmd_abs; // Absolute speed command
  logic [15:0] fb_abs; // Absolute speed feedback
  logic pos_mon; // Increasing direction supervised
  logic neg_mon; // Decreasing direction supervised
  logic dir_mon; // Any direction supervision
  logic lim_cmd_over; // Command above limit threshold
  logic lim_fb_over; // Feedback above limit threshold
  logic dir_cmd_over; // Command moving wrong way too fast
  logic dir_fb_over; // Feedback moving wrong way too fast
  logic below_exceed; // Either speed above low threshold
  logic below_rearm; // Both speeds under threshold less hysteresis
  logic trip_event; // Any monitor demands a trip
  logic below_d; // Next below-speed state
  logic [4:0] irq_event; // Events this cycle
  logic [speed_monitor_pkg::NUM_TIMERS-1:0] t_run; // Timer run levels
  logic [speed_monitor_pkg::NUM_TIMERS-1:0] t_done; // Timer expiry
  logic [15:0] t_time [speed_monitor_pkg::NUM_TIMERS]; // Timer times in units
  logic [31:0] unit_cycles; // Cycles per time unit

  assign unit_cycles = 32'(CYCLES_PER_UNIT);

  // APB decode, zero wait states
  assign setup_phase = PSEL && !PENABLE;
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign is_param = (PADDR >= speed_monitor_pkg::PARAM_BASE_OFS) && (PADDR[1:0] == 2'h0)
    && (PADDR[5:2] < 4'(speed_monitor_pkg::NUM_PARAMS)) && !PADDR[7];
  assign param_idx = PADDR[5:2];
  assign addr_ok = is_param || (PADDR == speed_monitor_pkg::CTRL_OFS)
    || (PADDR == speed_monitor_pkg::STATUS_OFS) || (PADDR == speed_monitor_pkg::IRQ_STATUS_OFS)
    || (PADDR == speed_monitor_pkg::IRQ_ENABLE_OFS) || (PADDR == speed_monitor_pkg::IRQ_CLEAR_OFS);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign PRDATA = prdata_q;
  assign trip_clr = wr_access && (PADDR == speed_monitor_pkg::CTRL_OFS)
    && PWDATA[speed_monitor_pkg::CTRL_TRIP_CLR];
  assign irq_clr = (wr_access && (PADDR == speed_monitor_pkg::IRQ_CLEAR_OFS)) ? PWDATA[4:0] : 5'h00;

  // Parameter table writes
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < speed_monitor_pkg::NUM_PARAMS; i++) begin
        param_q[i] <= speed_monitor_pkg::PARAM_RST;
      end
    end else if (wr_access && is_param) begin
      param_q[param_idx] <= PWDATA[15:0];
    end
  end

  // Control and interrupt enable writes
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brake_en_q <= speed_monitor_pkg::CTRL_RST[speed_monitor_pkg::CTRL_BRAKE_EN];
      irq_enable_q <= speed_monitor_pkg::IRQ_RST;
    end else if (wr_access) begin
      if (PADDR == speed_monitor_pkg::CTRL_OFS) begin
        brake_en_q <= PWDATA[speed_monitor_pkg::CTRL_BRAKE_EN];
      end
      if (PADDR == speed_monitor_pkg::IRQ_ENABLE_OFS) begin
        irq_enable_q <= PWDATA[4:0];
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_q <= 32'h00000000;
    end else if (setup_phase) begin
      prdata_q <= 32'h00000000;
      if (is_param) begin
        prdata_q <= {16'h0000, param_q[param_idx]};
      end else if (PADDR == speed_monitor_pkg::CTRL_OFS) begin
        prdata_q <= {31'h00000000, brake_en_q};
      end else if (PADDR == speed_monitor_pkg::STATUS_OFS) begin
        prdata_q <= {20'h00000, set_mon, 2'h0, BRAKE_RELEASE_OUT, neg_mon, pos_mon,
          lim_mon, below_q, trip_q};
      end else if (PADDR == speed_monitor_pkg::IRQ_STATUS_OFS) begin
        prdata_q <= {27'h0000000, irq_status_q};
      end else if (PADDR == speed_monitor_pkg::IRQ_ENABLE_OFS) begin
        prdata_q <= {27'h0000000, irq_enable_q};
      end
    end
  end

  // Limit set requests; the general request also selects set one
  assign set_act[0] = !LIMIT_SET1_REQUEST_N || !LIMITED_SPEED_REQUEST_N;
  assign set_act[1] = !LIMIT_SET2_REQUEST_N;
  assign set_act[2] = !LIMIT_SET3_REQUEST_N;
  assign set_act[3] = !LIMIT_SET4_REQUEST_N;

  // Direction requests
  assign pos_mon = t_done[speed_monitor_pkg::T_POS];
  assign neg_mon = t_done[speed_monitor_pkg::T_NEG];
  assign dir_mon = pos_mon || neg_mon;

  // Timer run levels and times
  always_comb begin
    for (int i = 0; i < speed_monitor_pkg::NUM_SETS; i++) begin
      t_run[speed_monitor_pkg::T_DECEL0 + i] = set_act[i];
      t_time[speed_monitor_pkg::T_DECEL0 + i] = param_q[speed_monitor_pkg::P_DECEL_TIME0 + i];
    end
    t_run[speed_monitor_pkg::T_POS] = !POSITIVE_DIR_REQUEST_N;
    t_time[speed_monitor_pkg::T_POS] = param_q[speed_monitor_pkg::P_POS_DELAY];
    t_run[speed_monitor_pkg::T_NEG] = !NEGATIVE_DIR_REQUEST_N;
    t_time[speed_monitor_pkg::T_NEG] = param_q[speed_monitor_pkg::P_NEG_DELAY];
    t_run[speed_monitor_pkg::T_LIM_CMD] = lim_cmd_pend_q;
    t_run[speed_monitor_pkg::T_LIM_FB] = lim_mon && lim_fb_over;
    t_run[speed_monitor_pkg::T_DIR_CMD] = dir_cmd_pend_q;
    t_run[speed_monitor_pkg::T_DIR_FB] = dir_mon && dir_fb_over;
    for (int i = speed_monitor_pkg::T_LIM_CMD; i < speed_monitor_pkg::NUM_TIMERS; i++) begin
      t_time[i] = param_q[speed_monitor_pkg::P_DETECT_DELAY];
    end
  end

  // One delay timer per slot, times scaled to cycles
  genvar g;
  generate
    for (g = 0; g < speed_monitor_pkg::NUM_TIMERS; g++) begin : g_timer
      monitor_delay_timer u_timer (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .run(t_run[g]),
        .limit(32'({16'h0000, t_time[g]} * unit_cycles)),
        .done(t_done[g])
      );
    end
  endgenerate

  assign set_mon = t_done[speed_monitor_pkg::T_DECEL0 +: 4];
  assign lim_mon = |set_mon;

  // Smallest threshold among monitoring sets
  always_comb begin
    lim_thr = 16'hFFFF;
    for (int i = 0; i < speed_monitor_pkg::NUM_SETS; i++) begin
      if (set_mon[i] && (param_q[speed_monitor_pkg::P_LIMIT_SPEED0 + i] < lim_thr)) begin
        lim_thr = param_q[speed_monitor_pkg::P_LIMIT_SPEED0 + i];
      end
    end
  end

  // Absolute speeds
  assign cmd_abs = SPEED_CMD[15] ? 16'(-SPEED_CMD) : 16'(SPEED_CMD);
  assign fb_abs = SPEED_FB[15] ? 16'(-SPEED_FB) : 16'(SPEED_FB);

  // Limit comparisons
  assign lim_cmd_over = cmd_abs > lim_thr;
  assign lim_fb_over = fb_abs > lim_thr;

  // Direction comparisons against the stop speed
  assign dir_cmd_over = (pos_mon && (SPEED_CMD > 0)
    && (16'(SPEED_CMD) > param_q[speed_monitor_pkg::P_STOP_SPEED]))
    || (neg_mon && (SPEED_CMD < 0) && (cmd_abs > param_q[speed_monitor_pkg::P_STOP_SPEED]));
  assign dir_fb_over = (pos_mon && (SPEED_FB > 0)
    && (16'(SPEED_FB) > param_q[speed_monitor_pkg::P_STOP_SPEED]))
    || (neg_mon && (SPEED_FB < 0) && (fb_abs > param_q[speed_monitor_pkg::P_STOP_SPEED]));

  // Command overspeed stays pending until its monitoring ends
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lim_cmd_pend_q <= 1'b0;
      dir_cmd_pend_q <= 1'b0;
    end else begin
      lim_cmd_pend_q <= lim_mon && (lim_cmd_pend_q || lim_cmd_over);
      dir_cmd_pend_q <= dir_mon && (dir_cmd_pend_q || dir_cmd_over);
    end
  end

  // Any expired detection delay trips
  assign trip_event = t_done[speed_monitor_pkg::T_LIM_CMD] || t_done[speed_monitor_pkg::T_LIM_FB]
    || t_done[speed_monitor_pkg::T_DIR_CMD] || t_done[speed_monitor_pkg::T_DIR_FB];

  // Trip latch; a new trip wins over a clear
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trip_q <= 1'b0;
    end else if (trip_event) begin
      trip_q <= 1'b1;
    end else if (trip_clr) begin
      trip_q <= 1'b0;
    end
  end

  // Below-speed hysteresis
  assign below_exceed = (cmd_abs > param_q[speed_monitor_pkg::P_LOW_THR])
    || (fb_abs > param_q[speed_monitor_pkg::P_LOW_THR]);
  assign below_rearm = ({1'b0, cmd_abs} + {1'b0, param_q[speed_monitor_pkg::P_LOW_HYST]}
    < {1'b0, param_q[speed_monitor_pkg::P_LOW_THR]})
    && ({1'b0, fb_abs} + {1'b0, param_q[speed_monitor_pkg::P_LOW_HYST]}
    < {1'b0, param_q[speed_monitor_pkg::P_LOW_THR]});

  always_comb begin
    below_d = below_q;
    if (below_exceed) begin
      below_d = 1'b0;
    end else if (!rearm_q) begin
      below_d = 1'b1;
    end else if (below_rearm) begin
      below_d = 1'b1;
    end
  end

  // Below-speed state
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      below_q <= 1'b0;
      rearm_q <= 1'b0;
    end else begin
      below_q <= below_d;
      if (below_q && !below_d) begin
        rearm_q <= 1'b1;
      end
    end
  end

  // Edge history for events
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lim_mon_q <= 1'b0;
      dir_mon_q <= 1'b0;
    end else begin
      lim_mon_q <= lim_mon;
      dir_mon_q <= dir_mon;
    end
  end

  assign irq_event = {dir_mon && !dir_mon_q, lim_mon && !lim_mon_q, !below_q && below_d,
    below_q && !below_d, trip_event && !trip_q};

  // Sticky interrupt status; set beats clear
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_status_q <= speed_monitor_pkg::IRQ_RST;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_event;
    end
  end

  // Outputs
  assign TORQUE_OFF_TRIP = trip_q;
  assign BELOW_SPEED_OUT = below_q;
  assign BRAKE_RELEASE_OUT = brake_en_q && !trip_q;
  assign IRQ = |(irq_status_q & irq_enable_q);

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  AST_TRIP_HELD: assert property (trip_q && !trip_clr |=> trip_q)
    else $error("Trip dropped without clear");
  AST_LIMIT_CMD_TRIP: assert property (t_done[speed_monitor_pkg::T_LIM_CMD] |=> TORQUE_OFF_TRIP)
    else $error("Limit command overspeed did not trip");
  // A zero detect delay expires at once, so the gap check needs a nonzero delay
  AST_LIMIT_FB_BREAK: assert property (lim_mon && !lim_fb_over
    && (param_q[speed_monitor_pkg::P_DETECT_DELAY] != 16'h0000) |=> !t_done[speed_monitor_pkg::T_LIM_FB])
    else $error("Feedback timer survived a gap");
  AST_DECEL_WAIT: assert property ($rose(set_act[0])
    && (param_q[speed_monitor_pkg::P_DECEL_TIME0] != 16'h0000) |-> !set_mon[0])
    else $error("Set one monitored before its deceleration time");
  // Pending overspeed is a register, so it clears one edge after monitoring stops
  AST_LIMIT_IDLE: assert property (set_act == 4'h0 |-> !lim_mon ##1 !lim_cmd_pend_q)
    else $error("Limit monitoring without request");
  AST_MIN_THR: assert property (set_mon[1] |-> lim_thr <= param_q[speed_monitor_pkg::P_LIMIT_SPEED0 + 1])
    else $error("Threshold above an active set");
  AST_BELOW_OFF: assert property (below_exceed |=> !BELOW_SPEED_OUT)
    else $error("Below output stayed on over threshold");
  AST_BELOW_REARM: assert property (rearm_q && !below_q && !below_rearm |=> !BELOW_SPEED_OUT)
    else $error("Below output rose inside hysteresis band");
  AST_BRAKE_HOLD: assert property (TORQUE_OFF_TRIP |-> !BRAKE_RELEASE_OUT)
    else $error("Brake released during trip");
  AST_DIR_END: assert property (POSITIVE_DIR_REQUEST_N |-> !pos_mon)
    else $error("Positive supervision without request");
  AST_DIR_FB_TRIP: assert property (t_done[speed_monitor_pkg::T_DIR_FB] |=> TORQUE_OFF_TRIP)
    else $error("Direction feedback fault did not trip");

  COV_LIMIT_TRIP: cover property (lim_mon ##1 TORQUE_OFF_TRIP);
  COV_DIR_TRIP: cover property (dir_mon ##1 TORQUE_OFF_TRIP);
  COV_BELOW_CYCLE: cover property (BELOW_SPEED_OUT ##1 !BELOW_SPEED_OUT ##[1:50] BELOW_SPEED_OUT);
  COV_TWO_SETS: cover property (set_mon[0] && set_mon[1]);

endmodule // safe_speed_direction_monitor

// ### safety_request_source.sv
// Model of the safety controller that drives the active-low request commands
`timescale 1ns/1ns
module safety_request_source (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] off_mask,
  output logic limit_n,
  output logic [3:0] set_n,
  output logic pos_n,
  output logic neg_n
);
  // Commands follow the mask one edge later; all stay on during reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // No monitoring requested
      limit_n <= 1'b1;
      set_n <= 4'hF;
      pos_n <= 1'b1;
      neg_n <= 1'b1;
    end else begin
      // Off requests, on ends the monitoring
      limit_n <= ~off_mask[0];
      set_n <= ~off_mask[4:1];
      pos_n <= ~off_mask[5];
      neg_n <= ~off_mask[6];
    end
  end
endmodule // safety_request_source

// ### safe_speed_direction_monitor_tb.sv
// Testbench for the speed and direction safety monitor
`timescale 1ns/1ns
module safe_speed_direction_monitor_tb;
  logic core_clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] off_mask;
  logic limit_n;
  logic [3:0] set_n;
  logic pos_n;
  logic neg_n;
  logic signed [15:0] cmd;
  logic signed [15:0] fb;
  logic trip;
  logic below;
  logic brake;
  logic irq;
  logic [31:0] rdata;
  logic rerr;
  int err_total = 0;
  int tests_run = 0;
  // Parameter table: stop, delay, low thr, hyst, pos, neg, limits 1..4, decel 1..4
  logic [15:0] pv [14] = '{16'h000A, 16'h0002, 16'h0064, 16'h0014, 16'h0001, 16'h0005,
    16'h0190, 16'h012C, 16'h00C8, 16'h01F4, 16'h0001, 16'h0001, 16'h0005, 16'h0001};

  // Clock at 100 ns period
  always #50 core_clk = ~core_clk;

  safety_request_source u_src (.clk(core_clk), .rst_n(rst_n), .off_mask(off_mask),
    .limit_n(limit_n), .set_n(set_n), .pos_n(pos_n), .neg_n(neg_n));

  safe_speed_direction_monitor #(.CYCLES_PER_UNIT(2)) u_dut (.CORE_CLK(core_clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LIMITED_SPEED_REQUEST_N(limit_n),
    .LIMIT_SET1_REQUEST_N(set_n[0]), .LIMIT_SET2_REQUEST_N(set_n[1]),
    .LIMIT_SET3_REQUEST_N(set_n[2]), .LIMIT_SET4_REQUEST_N(set_n[3]),
    .POSITIVE_DIR_REQUEST_N(pos_n), .NEGATIVE_DIR_REQUEST_N(neg_n), .SPEED_CMD(cmd),
    .SPEED_FB(fb), .TORQUE_OFF_TRIP(trip), .BELOW_SPEED_OUT(below),
    .BRAKE_RELEASE_OUT(brake), .IRQ(irq));

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compare one output flag
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Let n edges pass, then step clear of the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One APB transfer; read data and error taken at the completing edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Drive both speeds, then wait
  task automatic spd(input logic [15:0] c, input logic [15:0] f, input int n);
    @(posedge core_clk);
    cmd <= c;
    fb <= f;
    cyc(n);
  endtask

  // Command a request mask through the controller model, then wait
  task automatic req(input logic [6:0] m, input int n);
    @(posedge core_clk);
    off_mask <= m;
    cyc(n);
  endtask

  // End requests, stop motion, clear trip and pending events
  task automatic clr();
    req(7'h00, 2);
    spd(16'h0000, 16'h0000, 2);
    xfer(speed_monitor_pkg::CTRL_OFS, 1'b1, 32'h3);
    xfer(speed_monitor_pkg::IRQ_CLEAR_OFS, 1'b1, 32'h1F);
    cyc(2);
  endtask

  // Print counts and the verdict
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #2000000;
    err_total++;
    final_report();
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    off_mask = 7'h00;
    cmd = 16'h0000;
    fb = 16'h0000;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped address
    xfer(speed_monitor_pkg::CTRL_OFS, 1'b0, 32'h0);
    chk(rdata, 32'h0);
    xfer(speed_monitor_pkg::IRQ_ENABLE_OFS, 1'b0, 32'h0);
    chk(rdata, 32'h0);
    xfer(8'h20, 1'b0, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    for (int i = 0; i < 14; i++) begin
      xfer(speed_monitor_pkg::PARAM_BASE_OFS + 8'(4 * i), 1'b1, {16'h0, pv[i]});
      xfer(speed_monitor_pkg::PARAM_BASE_OFS + 8'(4 * i), 1'b0, 32'h0);
      chk(rdata, {16'h0, pv[i]});
    end
    xfer(speed_monitor_pkg::IRQ_ENABLE_OFS, 1'b1, 32'h1);
    xfer(speed_monitor_pkg::CTRL_OFS, 1'b1, 32'h1);
    cyc(3);
    chk1(brake, 1'b1);
    // Below-speed output with hysteresis
    chk1(below, 1'b1);
    spd(16'h0065, 16'h0000, 3);
    chk1(below, 1'b0);
    spd(16'h005A, 16'h0000, 3);
    chk1(below, 1'b0);
    spd(16'h004F, 16'h0000, 3);
    chk1(below, 1'b1);
    spd(16'h0000, 16'h0065, 3);
    chk1(below, 1'b0);
    // Limit sets 1 and 2 allow 250, set 3 does not
    spd(16'h00FA, 16'h0000, 0);
    req(7'h06, 20);
    chk1(trip, 1'b0);
    spd(16'h0000, 16'h0000, 0);
    req(7'h0E, 20);
    spd(16'h00FA, 16'h0000, 4);
    chk1(trip, 1'b0);
    cyc(6);
    chk1(trip, 1'b1);
    chk1(irq, 1'b1);
    xfer(speed_monitor_pkg::IRQ_STATUS_OFS, 1'b0, 32'h0);
    chk(rdata & 32'h1, 32'h1);
    // Status: sets 1 to 3 monitoring, limit monitoring, trip; below off, brake held
    xfer(speed_monitor_pkg::STATUS_OFS, 1'b0, 32'h0);
    chk(rdata, 32'h00000705);
    chk1(brake, 1'b0);
    req(7'h00, 4);
    chk1(trip, 1'b1);
    clr();
    chk1(trip, 1'b0);
    chk1(irq, 1'b0);
    chk1(brake, 1'b1);
    // Deceleration time of set 3 delays the comparison
    spd(16'h00FA, 16'h0000, 0);
    req(7'h08, 8);
    chk1(trip, 1'b0);
    cyc(20);
    chk1(trip, 1'b1);
    clr();
    // General limit request and its release
    spd(16'h01C2, 16'h0000, 0);
    req(7'h01, 30);
    chk1(trip, 1'b1);
    req(7'h00, 2);
    xfer(speed_monitor_pkg::CTRL_OFS, 1'b1, 32'h3);
    cyc(20);
    chk1(trip, 1'b0);
    clr();
    // Feedback must stay over for the whole detect delay
    req(7'h10, 10);
    spd(16'h0000, 16'h0258, 3);
    spd(16'h0000, 16'h0000, 5);
    chk1(trip, 1'b0);
    spd(16'h0000, 16'h0258, 10);
    chk1(trip, 1'b1);
    clr();
    // Positive direction, interrupt masked
    xfer(speed_monitor_pkg::IRQ_ENABLE_OFS, 1'b1, 32'h0);
    req(7'h20, 10);
    spd(16'h0000, 16'hFFCE, 10);
    chk1(trip, 1'b0);
    spd(16'h0000, 16'h0032, 10);
    chk1(trip, 1'b1);
    chk1(irq, 1'b0);
    req(7'h00, 2);
    xfer(speed_monitor_pkg::CTRL_OFS, 1'b1, 32'h3);
    cyc(10);
    chk1(trip, 1'b0);
    clr();
    // Negative direction with its own longer start delay
    spd(16'hFFCE, 16'h0000, 0);
    req(7'h40, 6);
    chk1(trip, 1'b0);
    cyc(25);
    chk1(trip, 1'b1);
    clr();
    final_report();
  end
endmodule // safe_speed_direction_monitor_tb
